// ### design/rst_seq_pkg.sv
// constants for the reset and power-up sequencer
package rst_seq_pkg;
   localparam int unsigned CLOCK_HZ        = 50_000_000;
   localparam int unsigned PUDT_MS         = 96;
   // power-up delay in rc oscillator ticks; rc rate arbitrary default
   localparam int unsigned RC_HZ           = 1_000_000;
   localparam int unsigned PUDT_TICKS      = PUDT_MS * (RC_HZ / 1000);
   localparam int unsigned PUDT_W          = 24;
   localparam int unsigned PHASE_W         = 2;
   localparam logic [1:0]  PHASE_Q1        = 2'h0;
   localparam logic        TIMEOUT_FLAG_RST   = 1'h1;
   localparam logic        POWERDOWN_FLAG_RST = 1'h1;
   localparam logic [7:0]  RETAINED_RST    = 8'h00;
   localparam logic [7:0]  DEFINED_RST     = 8'h00;
   typedef enum logic [1:0] {
      ST_POWER_OFF = 2'h0,
      ST_WAIT_PIN  = 2'h1,
      ST_DELAY     = 2'h3,
      ST_RUN       = 2'h2
   } seq_state_t;
endpackage : rst_seq_pkg

// ### design/reset_and_power_up_sequencer.sv
// reset combiner, power-up delay timer, phase-clock hold and strobe safing
`timescale 1ns/1ps
`default_nettype none
module reset_and_power_up_sequencer #(
   parameter int unsigned PUDT_TICKS = rst_seq_pkg::PUDT_TICKS  // shorten in simulation
) (
   input  wire logic       i_clock,            // system clock, 50 MHz
   input  wire logic       i_rstn,             // async reset, active low
   input  wire logic       i_power_good,       // supply above trip point
   input  wire logic       i_falling_detect_en,// later variant: reset on supply fall
   input  wire logic       i_master_clear_pin_n, // master clear, active low
   input  wire logic       i_watchdog_timeout, // watchdog time-out pulse
   input  wire logic       i_halt,             // core in low-power halt
   input  wire logic       i_rc_tick,          // one pulse per rc oscillator tick
   input  wire logic       i_ext_fetch_mode,   // mode allows external fetch
   input  wire logic [7:0] i_retained_wdata,   // write data for retained register
   input  wire logic       i_retained_we,      // retained register write
   input  wire logic       i_flags_clr,        // software sets both flags to 1
   output logic            o_reset,            // internal reset, active high
   output logic [1:0]      o_phase,            // four-phase clock, 0 = Q1
   output logic            o_wake,             // wake-up pulse from halt
   output logic            o_address_latch_strobe_pin, // strobe level
   output logic            o_address_latch_strobe_oe,  // strobe enable
   output logic            o_output_enable_strobe_pin, // strobe level
   output logic            o_write_strobe_pin,  // strobe level
   output logic            o_strobe_oe,         // oe and write strobe enable
   output logic            o_timeout_flag,      // 0 after watchdog time-out
   output logic            o_powerdown_flag,    // 0 after halt entry
   output logic [1:0]      o_cause,             // 0 none,1 por,2 master_clear_pin,3 wdt
   output logic [7:0]      o_retained,          // register unaffected by reset
   output logic [7:0]      o_defined            // register with defined reset
);
   typedef struct packed {
      rst_seq_pkg::seq_state_t st;
      logic [23:0] cnt;
      logic        rel_a;
      logic        rel_b;
      logic        reset;
      logic [1:0]  phase;
      logic        wake;
      logic        ale;
      logic        ale_oe;
      logic        oe_s;
      logic        wr_s;
      logic        s_oe;
      logic        to_f;
      logic        pd_f;
      logic [1:0]  cause;
      logic [7:0]  retained;
      logic [7:0]  defined;
   } state_t;

   state_t q, d;
   logic   supply_bad;
   logic   master_clear_pin_run, master_clear_pin_halt, wdt_run, wdt_halt, req;
   // last count of the delay; the timer stops there rather than wrapping
   localparam logic [23:0] PUDT_W_END = 24'(PUDT_TICKS - 1);

   always_comb begin
      supply_bad = !i_power_good && (q.st == rst_seq_pkg::ST_RUN ? i_falling_detect_en : 1'b1);
      master_clear_pin_run   = !i_master_clear_pin_n && !i_halt;
      master_clear_pin_halt  = !i_master_clear_pin_n && i_halt;
      wdt_run    = i_watchdog_timeout && !i_halt && q.st == rst_seq_pkg::ST_RUN;
      wdt_halt   = i_watchdog_timeout && i_halt && q.st == rst_seq_pkg::ST_RUN;
      req        = supply_bad || !i_master_clear_pin_n || wdt_run || q.st != rst_seq_pkg::ST_RUN;
      d = q;
      d.wake = 1'b0;
      if (supply_bad) begin
         d.st  = rst_seq_pkg::ST_POWER_OFF;
         d.cnt = '0;
      end else begin
         unique case (q.st)
            rst_seq_pkg::ST_POWER_OFF: d.st = rst_seq_pkg::ST_WAIT_PIN;
            rst_seq_pkg::ST_WAIT_PIN: if (i_master_clear_pin_n) begin
               d.st  = rst_seq_pkg::ST_DELAY;
               d.cnt = '0;
            end
            rst_seq_pkg::ST_DELAY: if (i_rc_tick) begin
               if (q.cnt == PUDT_W_END) d.st = rst_seq_pkg::ST_RUN;
               else d.cnt = q.cnt + 24'h000001;
            end
            rst_seq_pkg::ST_RUN: ;
         endcase
      end
      // two-stage release; assert immediately, release three clocks after the request clears
      d.rel_a = !req;
      d.rel_b = q.rel_a && !req;
      d.reset = !(q.rel_b && !req);
      d.phase = d.reset ? rst_seq_pkg::PHASE_Q1 : q.phase + 2'h1;
      d.ale    = 1'b0;
      d.ale_oe = d.reset && i_ext_fetch_mode;
      d.oe_s   = 1'b1;
      d.wr_s   = 1'b1;
      d.s_oe   = d.reset && i_ext_fetch_mode;
      if (q.st == rst_seq_pkg::ST_POWER_OFF) begin
         d.cause = 2'h1;
         d.to_f  = 1'b1;
         d.pd_f  = 1'b1;
      end else if (wdt_run) begin
         d.cause = 2'h3;
         d.to_f  = 1'b0;
         d.pd_f  = 1'b1;
      end else if (wdt_halt) begin
         d.to_f  = 1'b0;
         d.pd_f  = 1'b0;
         d.wake  = 1'b1;
      end else if (master_clear_pin_halt) begin
         d.cause = 2'h2;
         d.pd_f  = 1'b0;
      end else if (master_clear_pin_run) begin
         d.cause = 2'h2;
      end else if (i_flags_clr) begin
         d.to_f = 1'b1;
         d.pd_f = 1'b1;
      end else if (i_halt && !q.reset) begin
         d.pd_f = 1'b0;
      end
      if (i_retained_we && !q.reset) d.retained = i_retained_wdata;
      if (q.reset && !wdt_halt) d.defined = rst_seq_pkg::DEFINED_RST;
      else if (i_retained_we) d.defined = i_retained_wdata;
   end

   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         q          <= '0;
         q.st       <= rst_seq_pkg::ST_POWER_OFF;
         q.reset    <= 1'b1;
         q.oe_s     <= 1'b1;
         q.wr_s     <= 1'b1;
         q.to_f     <= rst_seq_pkg::TIMEOUT_FLAG_RST;
         q.pd_f     <= rst_seq_pkg::POWERDOWN_FLAG_RST;
         q.retained <= rst_seq_pkg::RETAINED_RST;
         q.defined  <= rst_seq_pkg::DEFINED_RST;
      end else begin
         q <= d;
      end
   end

   assign o_reset                    = q.reset;
   assign o_phase                    = q.phase;
   assign o_wake                     = q.wake;
   assign o_address_latch_strobe_pin = q.ale;
   assign o_address_latch_strobe_oe  = q.ale_oe;
   assign o_output_enable_strobe_pin = q.oe_s;
   assign o_write_strobe_pin         = q.wr_s;
   assign o_strobe_oe                = q.s_oe;
   assign o_timeout_flag             = q.to_f;
   assign o_powerdown_flag           = q.pd_f;
   assign o_cause                    = q.cause;
   assign o_retained                 = q.retained;
   assign o_defined                  = q.defined;

   property p_phase_hold;
      @(posedge i_clock) disable iff (!i_rstn) o_reset |-> o_phase == rst_seq_pkg::PHASE_Q1;
   endproperty
   a_phase_hold: assert property (p_phase_hold) else $error("phase not held in reset");
   property p_strobes;
      @(posedge i_clock) disable iff (!i_rstn)
         (o_reset && o_strobe_oe) |-> (!o_address_latch_strobe_pin && o_output_enable_strobe_pin && o_write_strobe_pin);
   endproperty
   a_strobes: assert property (p_strobes) else $error("strobes not safe in reset");
   property p_supply;
      @(posedge i_clock) disable iff (!i_rstn) (!i_power_good && q.st != rst_seq_pkg::ST_RUN) |=> ##1 o_reset;
   endproperty
   a_supply: assert property (p_supply) else $error("reset not held on low supply");
   property p_delay;
      @(posedge i_clock) disable iff (!i_rstn) q.st == rst_seq_pkg::ST_DELAY |=> o_reset;
   endproperty
   a_delay: assert property (p_delay) else $error("reset released while delay runs");
   property p_tick_only;
      @(posedge i_clock) disable iff (!i_rstn)
         (q.st == rst_seq_pkg::ST_DELAY && !i_rc_tick && i_power_good) |=> $stable(q.cnt);
   endproperty
   a_tick_only: assert property (p_tick_only) else $error("delay counted without rc tick");
   property p_wdt_run;
      @(posedge i_clock) disable iff (!i_rstn) wdt_run && !supply_bad && q.st != rst_seq_pkg::ST_POWER_OFF
         |=> !o_timeout_flag && o_cause == 2'h3 ##1 o_reset;
   endproperty
   a_wdt_run: assert property (p_wdt_run) else $error("watchdog reset not flagged");
   property p_wake;
      @(posedge i_clock) disable iff (!i_rstn) wdt_halt && !supply_bad && !master_clear_pin_halt |=> o_wake && !o_powerdown_flag;
   endproperty
   a_wake: assert property (p_wake) else $error("halt watchdog not a wake-up");
   property p_retained;
      @(posedge i_clock) disable iff (!i_rstn) o_reset && !i_retained_we |=> $stable(o_retained);
   endproperty
   a_retained: assert property (p_retained) else $error("retained register changed by reset");
   property p_defined;
      @(posedge i_clock) disable iff (!i_rstn) o_reset && !wdt_halt |=> o_defined == rst_seq_pkg::DEFINED_RST;
   endproperty
   a_defined: assert property (p_defined) else $error("defined register not reset");
   property p_release;
      @(posedge i_clock) disable iff (!i_rstn) $fell(o_reset) |-> $past(q.rel_b);
   endproperty
   a_release: assert property (p_release) else $error("reset release not synchronised");
   c_release: cover property (@(posedge i_clock) disable iff (!i_rstn) $fell(o_reset));
   c_wdt:     cover property (@(posedge i_clock) disable iff (!i_rstn) wdt_run);
   c_wake:    cover property (@(posedge i_clock) disable iff (!i_rstn) o_wake);
   c_supply_fall: cover property (@(posedge i_clock) disable iff (!i_rstn)
      !i_power_good && i_falling_detect_en && q.st == rst_seq_pkg::ST_RUN);
   // later variant: a supply fall resets from any state, run included
   property p_supply_fall;
      @(posedge i_clock) disable iff (!i_rstn) (!i_power_good && i_falling_detect_en) |=> o_reset;
   endproperty
   a_supply_fall: assert property (p_supply_fall) else $error("reset not raised on supply fall");
   // out of reset the phase must step through all four states in turn
   property p_phase_run;
      @(posedge i_clock) disable iff (!i_rstn) !o_reset ##1 !o_reset |-> o_phase == $past(o_phase) + 2'h1;
   endproperty
   a_phase_run: assert property (p_phase_run) else $error("phase clock not advancing");
endmodule : reset_and_power_up_sequencer
`default_nettype wire

// ### test/supply_pin_model.sv
// supply detector, master clear pin and rc oscillator model
`timescale 1ns/1ps
`default_nettype none
module supply_pin_model (
   input  wire logic i_clock,            // system clock
   input  wire logic i_supply_on,        // supply above trip point
   input  wire logic i_pin_low,          // hold master clear low
   input  wire logic i_slow,             // slow rc oscillator
   output logic      o_power_good,        // detector output
   output logic      o_pin_n,             // master clear level
   output logic      o_rc_tick = 1'h0     // rc oscillator tick
);
   int cnt = 0;
   // levels pass straight through, so falling-edge stimulus reaches the pins without a race
   assign o_power_good = i_supply_on;
   assign o_pin_n      = ~i_pin_low;
   // rc oscillator runs free from power-up, divided down from the falling edge of the core clock
   always @(negedge i_clock) begin
      cnt          <= (cnt >= (i_slow ? 9 : 2)) ? 0 : cnt + 1;
      o_rc_tick    <= (cnt == 0);
   end
endmodule : supply_pin_model
`default_nettype wire

// ### test/reset_and_power_up_sequencer_bench.sv
// self-checking bench for the reset and power-up sequencer
`timescale 1ns/1ps
`default_nettype none
module reset_and_power_up_sequencer_bench;
   localparam int unsigned TICKS = 4;
   logic i_clock = 0, i_rstn = 0, supply_on = 0, pin_low = 0, slow = 0;
   logic i_falling_detect_en = 0, i_watchdog_timeout = 0, i_halt = 0, i_ext_fetch_mode = 1;
   logic [7:0] i_retained_wdata = 8'h00;
   logic i_retained_we = 0, i_flags_clr = 0;
   logic pg, pin_n, tick, o_reset, o_wake, o_timeout_flag, o_powerdown_flag;
   logic o_address_latch_strobe_pin, o_address_latch_strobe_oe, o_output_enable_strobe_pin;
   logic o_write_strobe_pin, o_strobe_oe;
   logic [1:0] o_phase, o_cause;
   logic [7:0] o_retained, o_defined;
   int err_total = 0, checked = 0, n;
   // bench model; -1 marks a value the rules leave unknown
   int exp_cause, exp_to, exp_pd, exp_ret = -1, exp_def = 0;
   always #10 i_clock = ~i_clock;
   supply_pin_model model (.i_clock(i_clock), .i_supply_on(supply_on), .i_pin_low(pin_low), .i_slow(slow),
      .o_power_good(pg), .o_pin_n(pin_n), .o_rc_tick(tick));
   reset_and_power_up_sequencer #(.PUDT_TICKS(TICKS)) uut (
      .i_clock(i_clock), .i_rstn(i_rstn), .i_power_good(pg), .i_falling_detect_en(i_falling_detect_en),
      .i_master_clear_pin_n(pin_n), .i_watchdog_timeout(i_watchdog_timeout), .i_halt(i_halt),
      .i_rc_tick(tick), .i_ext_fetch_mode(i_ext_fetch_mode), .i_retained_wdata(i_retained_wdata),
      .i_retained_we(i_retained_we), .i_flags_clr(i_flags_clr), .o_reset(o_reset), .o_phase(o_phase),
      .o_wake(o_wake), .o_address_latch_strobe_pin(o_address_latch_strobe_pin),
      .o_address_latch_strobe_oe(o_address_latch_strobe_oe),
      .o_output_enable_strobe_pin(o_output_enable_strobe_pin), .o_write_strobe_pin(o_write_strobe_pin),
      .o_strobe_oe(o_strobe_oe), .o_timeout_flag(o_timeout_flag), .o_powerdown_flag(o_powerdown_flag),
      .o_cause(o_cause), .o_retained(o_retained), .o_defined(o_defined));
   task automatic chk(string name, logic [7:0] got, int exp);
      checked++;
      if (got !== 8'(exp)) begin
         err_total++;
         $display("ERROR %s expected %0d seen %0d", name, exp, got);
      end
   endtask : chk
   task automatic chk_state();
      chk("cause", o_cause, exp_cause);
      if (exp_to >= 0) chk("timeout_flag", o_timeout_flag, exp_to);
      chk("powerdown_flag", o_powerdown_flag, exp_pd);
      if (exp_ret >= 0) chk("retained", o_retained, exp_ret);
      chk("defined", o_defined, exp_def);
   endtask : chk_state
   // follows a reset to its release, checking what must hold meanwhile
   task automatic hold_check(int min_cyc);
      int c;
      logic [1:0] ph;
      c = 0;
      while (o_reset === 1'h1 && c < 2000) begin
         chk("phase", o_phase, rst_seq_pkg::PHASE_Q1);
         chk("strobe_oe", {o_address_latch_strobe_oe, o_strobe_oe}, i_ext_fetch_mode ? 3 : 0);
         if (i_ext_fetch_mode) chk("strobes", {o_address_latch_strobe_pin, o_output_enable_strobe_pin, o_write_strobe_pin}, 3);
         @(negedge i_clock);
         c++;
      end
      chk("released", o_reset, 0);
      if (c < min_cyc) chk("hold_too_short", 8'h00, 1);
      ph = o_phase;
      @(negedge i_clock);
      chk("phase_run", o_phase, 2'(ph + 2'h1));
      chk_state();
   endtask : hold_check
   task automatic write_data();
      i_retained_wdata = 8'($urandom());
      i_retained_we = 1;
      @(negedge i_clock);
      i_retained_we = 0;
      exp_ret = i_retained_wdata;
      exp_def = i_retained_wdata;
      @(negedge i_clock);
      chk_state();
   endtask : write_data
   task automatic pulse_watchdog(int gap);
      i_watchdog_timeout = 1;
      n = 0;
      repeat (gap) begin
         @(negedge i_clock);
         i_watchdog_timeout = 0;
         if (o_wake === 1'h1) n++;
      end
   endtask : pulse_watchdog
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : end_of_test
   initial begin
      #400us;
      err_total++;
      end_of_test();
   end
   initial begin
      void'($urandom(91825));
      repeat (8) @(negedge i_clock);
      i_rstn = 1;
      repeat (10) @(negedge i_clock);
      chk("reset_low_supply", o_reset, 1);
      supply_on = 1;
      {exp_cause, exp_to, exp_pd} = {32'd1, 32'd1, 32'd1};
      hold_check((TICKS - 1) * 3);
      write_data();
      pulse_watchdog(3);
      chk("watchdog_reset", o_reset, 1);
      {exp_cause, exp_to, exp_def} = {32'd3, 32'd0, 32'd0};
      hold_check(0);
      i_flags_clr = 1;
      @(negedge i_clock);
      i_flags_clr = 0;
      {exp_to, exp_pd} = {32'd1, 32'd1};
      @(negedge i_clock);
      chk_state();
      write_data();
      i_halt = 1;
      pulse_watchdog(4);
      chk("wake_cycles", 8'(n), 1);
      chk("no_reset_in_halt", o_reset, 0);
      {exp_to, exp_pd} = {32'd0, 32'd0};
      chk_state();
      {pin_low, slow} = 2'h3;
      repeat (3) @(negedge i_clock);
      chk("pin_reset", o_reset, 1);
      i_ext_fetch_mode = 0;
      repeat (5) @(negedge i_clock);
      pin_low = 0;
      {exp_cause, exp_to, exp_def} = {32'd2, -32'sd1, 32'd0};
      hold_check(0);
      // master clear in run: flags left as they were
      i_halt = 0;
      pin_low = 1;
      repeat (3) @(negedge i_clock);
      chk("pin_run_reset", o_reset, 1);
      pin_low = 0;
      hold_check(0);
      // earliest variant ignores a falling supply once running
      supply_on = 0;
      repeat (4) @(negedge i_clock);
      chk("no_fall_reset", o_reset, 0);
      {i_halt, i_ext_fetch_mode, i_falling_detect_en, supply_on} = 4'h6;
      repeat (3) @(negedge i_clock);
      chk("supply_fall_reset", o_reset, 1);
      repeat (5) @(negedge i_clock);
      supply_on = 1;
      {exp_cause, exp_to, exp_pd, exp_ret} = {32'd1, 32'd1, 32'd1, -32'sd1};
      hold_check((TICKS - 1) * 10);
      end_of_test();
   end
endmodule : reset_and_power_up_sequencer_bench
`default_nettype wire
